// >>> rtl/fmp_fpu_end.sv
`timescale 1ns/1ps
module fmp_fpu_end
    import fmp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    fmp_link_if.dev LINK,
    input wire logic [2:0] RD_SEL_I,
    input wire logic FLAG_CLR_I,
    output logic [31:0] RD_DATA_O,
    output logic [6:0] STATUS_O
);

    ////////////////////////////////////////////////////////////////////////
    // arithmetic helpers

    // single-precision multiply, truncating; returns {unf, ovf, result}
    function automatic logic [33:0] fmp_fmul(input logic [31:0] a, input logic [31:0] b);
        logic sgn;
        logic [47:0] prod;
        logic signed [9:0] ex;
        logic [22:0] man;
        sgn = a[31] ^ b[31];
        prod = 48'({1'b1, a[22:0]}) * 48'({1'b1, b[22:0]});
        ex = $signed({2'b00, a[30:23]}) + $signed({2'b00, b[30:23]}) - 10'sd127;
        man = prod[45:23];
        // denormals flush to zero, so a zero exponent means a zero operand
        if (a[30:23] == 8'h00 || b[30:23] == 8'h00) begin
            return {2'b00, sgn, 31'h0};
        end
        if (prod[47]) begin
            man = prod[46:24];
            ex = ex + 10'sd1;
        end
        if (ex >= 10'sd255) begin
            return {2'b01, sgn, 8'hff, 23'h0};
        end
        if (ex <= 10'sd0) begin
            return {2'b10, sgn, 31'h0};
        end
        return {2'b00, sgn, ex[7:0], man};
    endfunction

    // single-precision a - b, truncating; returns {unf, ovf, result}
    function automatic logic [33:0] fmp_fsub(input logic [31:0] a, input logic [31:0] b);
        logic [31:0] x;
        logic [31:0] y;
        logic [7:0] diff;
        logic [24:0] mx;
        logic [24:0] my;
        logic [24:0] sum;
        logic [24:0] norm;
        logic [4:0] lead;
        logic signed [9:0] ex;
        x = a;
        y = {~b[31], b[30:0]};
        lead = 5'd0;
        if (y[30:23] == 8'h00) begin
            return {2'b00, (x[30:23] == 8'h00) ? 32'h0 : x};
        end
        if (x[30:23] == 8'h00) begin
            return {2'b00, y};
        end
        // larger magnitude first so the difference never goes negative
        if (x[30:0] < y[30:0]) begin
            x = y;
            y = a;
        end
        diff = x[30:23] - y[30:23];
        mx = {2'b01, x[22:0]};
        my = (diff > 8'd24) ? 25'h0 : ({2'b01, y[22:0]} >> diff);
        sum = (x[31] == y[31]) ? (mx + my) : (mx - my);
        if (sum == 25'h0) begin
            return {2'b00, 32'h0};
        end
        for (int i = 0; i < 25; i++) begin
            if (sum[i]) begin
                lead = 5'(i);
            end
        end
        norm = sum << (5'd24 - lead);
        ex = $signed({2'b00, x[30:23]}) + $signed({5'b00000, lead}) - 10'sd23;
        if (ex >= 10'sd255) begin
            return {2'b01, x[31], 8'hff, 23'h0};
        end
        if (ex <= 10'sd0) begin
            return {2'b10, x[31], 31'h0};
        end
        return {2'b00, x[31], ex[7:0], norm[23:1]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // decode of the issued word

    logic [31:0] fpr_q [REG_CNT]; // result registers zero to seven
    fmp_op_e op; // decoded operation
    fmp_fields_s fld; // decoded operand fields
    logic [33:0] mul_res; // multiply result with flags
    logic [33:0] sub_res; // subtract result with flags
    logic is_mpy; // any of the three paired ops
    logic is_load; // issued multiply with parallel load
    logic [31:0] ld_word; // word being loaded

    assign op = LINK.issue_valid ? fmp_decode(LINK.issue_word) : FMP_OP_NONE;
    assign fld = fmp_fields(LINK.issue_word);
    assign is_mpy = (op != FMP_OP_NONE);
    assign is_load = (op == FMP_OP_MPY_LOAD);
    assign ld_word = LINK.load_word;
    assign mul_res = fmp_fmul(fpr_q[fld.msrc_a], fpr_q[fld.msrc_b]);
    assign sub_res = fmp_fsub(fpr_q[fld.osrc_a], fpr_q[fld.osrc_b]);

    ////////////////////////////////////////////////////////////////////////
    // second pipeline stage: results wait one cycle before write-back

    logic mul_v_q; // product waiting for write-back
    logic [2:0] mul_dst_q; // product destination
    logic [31:0] mul_q; // product value
    logic sub_v_q; // difference waiting for write-back
    logic [2:0] sub_dst_q; // difference destination
    logic [31:0] sub_q; // difference value
    logic unf_q; // underflow from either unit
    logic ovf_q; // overflow from either unit

    // capture results at issue so they land one delay slot later
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mul_v_q <= 1'b0;
            mul_dst_q <= 3'h0;
            mul_q <= 32'h0;
            sub_v_q <= 1'b0;
            sub_dst_q <= 3'h0;
            sub_q <= 32'h0;
            unf_q <= 1'b0;
            ovf_q <= 1'b0;
        end else begin
            mul_v_q <= is_mpy;
            mul_dst_q <= fld.mdst;
            mul_q <= mul_res[31:0];
            sub_v_q <= (op == FMP_OP_MPY_SUB);
            sub_dst_q <= fld.odst;
            sub_q <= sub_res[31:0];
            // subtract flags only count for the subtract op
            unf_q <= is_mpy & (mul_res[33] | ((op == FMP_OP_MPY_SUB) & sub_res[33]));
            ovf_q <= is_mpy & (mul_res[32] | ((op == FMP_OP_MPY_SUB) & sub_res[32]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register file

    // older write-back first, the newer load last so it wins a collision
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            for (int i = 0; i < REG_CNT; i++) begin
                fpr_q[i] <= 32'h0;
            end
        end else begin
            if (mul_v_q) begin
                fpr_q[mul_dst_q] <= mul_q;
            end
            if (sub_v_q) begin
                fpr_q[sub_dst_q] <= sub_q;
            end
            if (is_load) begin
                fpr_q[fld.odst] <= ld_word;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parallel store toward memory

    // request stands one cycle; memory holds the word at the next edge
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            LINK.store_valid <= 1'b0;
            LINK.store_addr <= 8'h00;
            LINK.store_word <= 32'h0;
        end else begin
            LINK.store_valid <= (op == FMP_OP_MPY_STORE);
            LINK.store_addr <= fld.mem;
            LINK.store_word <= fpr_q[fld.odst];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status word

    logic [6:0] stat_q; // status word

    // latched bits are sticky; a set in the clear cycle wins
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            stat_q <= STAT_RST;
        end else begin
            stat_q[ST_LAT_UNF] <= unf_q | (stat_q[ST_LAT_UNF] & ~FLAG_CLR_I);
            stat_q[ST_LAT_OVF] <= ovf_q | (stat_q[ST_LAT_OVF] & ~FLAG_CLR_I);
            if (is_load) begin
                // exponent zero forces a positive zero
                if (ld_word[30:23] == 8'h00) begin
                    stat_q[ST_NEG] <= 1'b0;
                    stat_q[ST_ZERO] <= 1'b1;
                end else begin
                    stat_q[ST_NEG] <= ld_word[31];
                    stat_q[ST_ZERO] <= 1'b0;
                end
                stat_q[ST_INT_NEG] <= ld_word[31];
                stat_q[ST_INT_ZERO] <= (ld_word == 32'h0);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // user-side read port

    // registered, so a read sees state one cycle old
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            RD_DATA_O <= 32'h0;
        end else begin
            RD_DATA_O <= fpr_q[RD_SEL_I];
        end
    end

    assign STATUS_O = stat_q;

endmodule

// >>> rtl/fmp_pkg.sv
package fmp_pkg;
    localparam int DATA_W = 32; // register and memory word width
    localparam int REG_CNT = 8; // result registers zero to seven
    localparam int REG_IDX_W = 3; // register field width
    localparam int MEM_ADDR_W = 8; // memory operand field width
    localparam int MEM_DEPTH = 256; // words behind the memory operand
    localparam int STAT_W = 7; // status word width
    localparam int MPY_LAT = 2; // pipeline cycles of multiply and subtract

    // opcode prefixes in the upper bits of the instruction word
    localparam logic [11:0] OPC_MPY_LOAD = 12'he30;
    localparam logic [11:0] OPC_MPY_STORE = 12'he00;
    localparam logic [13:0] OPC_MPY_SUB = 14'h39d4;

    // status word bit positions
    localparam int ST_LAT_OVF = 0; // latched overflow
    localparam int ST_LAT_UNF = 1; // latched underflow
    localparam int ST_NEG = 2; // negative
    localparam int ST_ZERO = 3; // zero
    localparam int ST_INT_NEG = 4; // integer negative
    localparam int ST_INT_ZERO = 5; // integer zero
    localparam int ST_TEST = 6; // test flag, untouched here
    localparam logic [6:0] STAT_RST = 7'h00;

    typedef enum logic [1:0] {
        FMP_OP_NONE,
        FMP_OP_MPY_LOAD,
        FMP_OP_MPY_STORE,
        FMP_OP_MPY_SUB
    } fmp_op_e;

    // operand fields: product pair and second (move or subtract) operation
    typedef struct packed {
        logic [2:0] mdst;
        logic [2:0] msrc_a;
        logic [2:0] msrc_b;
        logic [2:0] odst;
        logic [2:0] osrc_a;
        logic [2:0] osrc_b;
        logic [7:0] mem;
    } fmp_fields_s;

    // opcode decode, shared by both ends
    function automatic fmp_op_e fmp_decode(input logic [31:0] w);
        if (w[31:20] == OPC_MPY_LOAD) begin
            return FMP_OP_MPY_LOAD;
        end else if (w[31:20] == OPC_MPY_STORE) begin
            return FMP_OP_MPY_STORE;
        end else if (w[31:18] == OPC_MPY_SUB) begin
            return FMP_OP_MPY_SUB;
        end
        return FMP_OP_NONE;
    endfunction

    // field extraction; subtract uses its own layout, load and store share the other
    function automatic fmp_fields_s fmp_fields(input logic [31:0] w);
        fmp_fields_s f;
        f = '0;
        if (fmp_decode(w) == FMP_OP_MPY_SUB) begin
            f.mdst = w[2:0];
            f.msrc_a = w[5:3];
            f.msrc_b = w[8:6];
            f.odst = w[11:9];
            f.osrc_a = w[14:12];
            f.osrc_b = {w[17:16], w[15]};
        end else begin
            f.msrc_b = w[19:17];
            f.msrc_a = {w[16], w[15:14]};
            f.mdst = w[13:11];
            f.odst = w[10:8];
            f.mem = w[7:0];
        end
        return f;
    endfunction
endpackage

// >>> rtl/fmp_link_if.sv
`timescale 1ns/1ps
// pipeline link between issuing cpu and floating-point end
interface fmp_link_if;
    logic issue_valid; // one-cycle instruction issue
    logic [31:0] issue_word; // instruction word
    logic [31:0] load_word; // memory word for a parallel load
    logic store_valid; // one-cycle memory write request
    logic [7:0] store_addr; // memory word address
    logic [31:0] store_word; // data to write

    modport dev (
        input issue_valid, issue_word, load_word,
        output store_valid, store_addr, store_word
    );
    modport host (
        output issue_valid, issue_word, load_word,
        input store_valid, store_addr, store_word
    );
endinterface

// >>> rtl/fmp_cpu_end.sv
`timescale 1ns/1ps
module fmp_cpu_end
    import fmp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    fmp_link_if.host LINK,
    input wire logic INSTR_VALID_I,
    input wire logic [31:0] INSTR_I,
    input wire logic MEM_WE_I,
    input wire logic [7:0] MEM_ADDR_I,
    input wire logic [31:0] MEM_WDATA_I,
    output logic INSTR_READY_O,
    output logic REJECT_O,
    output logic [31:0] MEM_RDATA_O
);

    ////////////////////////////////////////////////////////////////////////
    // hazard and restriction checks

    // registers an instruction reads or writes, as a mask with one bit per register
    function automatic logic [7:0] fmp_touch(input logic [31:0] w);
        fmp_fields_s f;
        logic [7:0] m;
        f = fmp_fields(w);
        m = 8'h00;
        if (fmp_decode(w) != FMP_OP_NONE) begin
            m[f.mdst] = 1'b1;
            m[f.msrc_a] = 1'b1;
            m[f.msrc_b] = 1'b1;
            m[f.odst] = 1'b1;
        end
        if (fmp_decode(w) == FMP_OP_MPY_SUB) begin
            m[f.osrc_a] = 1'b1;
            m[f.osrc_b] = 1'b1;
        end
        return m;
    endfunction

    logic [31:0] mem_q [MEM_DEPTH]; // data memory
    logic [7:0] pend_q; // destinations still in the delay slot
    fmp_op_e op; // decoded user instruction
    fmp_fields_s fld; // its fields
    logic conflict; // touches a pending destination
    logic illegal; // same destination for both results
    logic take; // instruction accepted this cycle

    assign op = fmp_decode(INSTR_I);
    assign fld = fmp_fields(INSTR_I);
    assign conflict = |(fmp_touch(INSTR_I) & pend_q);
    assign illegal = (op == FMP_OP_MPY_LOAD || op == FMP_OP_MPY_SUB)
        && (fld.mdst == fld.odst);
    // a conflicting instruction waits one cycle: the slot becomes a bubble
    assign INSTR_READY_O = !conflict;
    assign take = INSTR_VALID_I & !conflict;

    ////////////////////////////////////////////////////////////////////////
    // issue stage

    // pending mask lives exactly one cycle, the single delay slot
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            pend_q <= 8'h00;
            LINK.issue_valid <= 1'b0;
            LINK.issue_word <= 32'h0;
            LINK.load_word <= 32'h0;
            REJECT_O <= 1'b0;
        end else begin
            LINK.issue_valid <= take & !illegal;
            LINK.issue_word <= INSTR_I;
            LINK.load_word <= mem_q[fld.mem];
            REJECT_O <= take & illegal;
            pend_q <= 8'h00;
            if (take && !illegal && op != FMP_OP_NONE) begin
                pend_q[fld.mdst] <= 1'b1;
                if (op == FMP_OP_MPY_SUB) begin
                    pend_q[fld.odst] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data memory

    // store from the link lands after the user write, so it wins
    always_ff @(posedge CORE_CLK_I) begin
        if (MEM_WE_I) begin
            mem_q[MEM_ADDR_I] <= MEM_WDATA_I;
        end
        if (LINK.store_valid) begin
            mem_q[LINK.store_addr] <= LINK.store_word;
        end
    end

    // registered user read
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            MEM_RDATA_O <= 32'h0;
        end else begin
            MEM_RDATA_O <= mem_q[MEM_ADDR_I];
        end
    end

endmodule

// >>> testbench/fmp_link_checker.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// link checks; delay-slot hazards are the issuing end's duty
module fmp_link_checker
    import fmp_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic issue_valid,
    input wire logic [31:0] issue_word,
    input wire logic [31:0] load_word,
    input wire logic store_valid,
    input wire logic [7:0] store_addr,
    input wire logic [31:0] store_word
);
    logic [31:0] prev_q; // word seen one cycle back
    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);
    // one-hot of a register index
    function automatic logic [7:0] oh(input logic [2:0] r);
        return 8'h01 << r;
    endfunction
    // registers named by any field of a paired word
    function automatic logic [7:0] uses(input logic [31:0] w);
        if (w[31:18] == OPC_MPY_SUB) begin
            return oh(w[2:0]) | oh(w[5:3]) | oh(w[8:6]) | oh(w[11:9])
                | oh(w[14:12]) | oh(w[17:15]);
        end
        if (w[31:20] == OPC_MPY_LOAD || w[31:20] == OPC_MPY_STORE) begin
            return oh(w[19:17]) | oh(w[16:14]) | oh(w[13:11]) | oh(w[10:8]);
        end
        return 8'h00; // other opcodes touch no result register
    endfunction
    // word history; only meaningful when valid was high
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            prev_q <= 32'h0;
        end else begin
            prev_q <= issue_word;
        end
    end
    sequence s_store;
        issue_valid && issue_word[31:20] == OPC_MPY_STORE;
    endsequence
    sequence s_pair;
        issue_valid ##1 issue_valid;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    chk_store_pulse: assert property (s_store |=> store_valid)
        else $error("no store request after a store issue");
    chk_store_addr: assert property (s_store |=> store_addr == prev_q[7:0])
        else $error("store address differs from the memory field");
    chk_store_cause: assert property (store_valid |->
        $past(issue_valid) && prev_q[31:20] == OPC_MPY_STORE)
        else $error("store request without a store issue");
    chk_load_unique: assert property (issue_valid && issue_word[31:20] == OPC_MPY_LOAD |->
        issue_word[13:11] != issue_word[10:8])
        else $error("load issued with shared destination");
    chk_sub_unique: assert property (issue_valid && issue_word[31:18] == OPC_MPY_SUB |->
        issue_word[2:0] != issue_word[11:9])
        else $error("subtract issued with shared destination");
    chk_slot_load: assert property (s_pair |-> prev_q[31:20] != OPC_MPY_LOAD ||
        (uses(issue_word) & oh(prev_q[13:11])) == 8'h00)
        else $error("slot after load touches product register");
    chk_slot_store: assert property (s_pair |-> prev_q[31:20] != OPC_MPY_STORE ||
        (uses(issue_word) & oh(prev_q[13:11])) == 8'h00)
        else $error("slot after store touches product register");
    chk_slot_sub: assert property (s_pair |-> prev_q[31:18] != OPC_MPY_SUB ||
        (uses(issue_word) & (oh(prev_q[2:0]) | oh(prev_q[11:9]))) == 8'h00)
        else $error("slot after subtract touches a result register");
endmodule

// >>> testbench/fp_multiply_parallel_ops_tb_top.sv
`timescale 1ns/1ps
module fp_multiply_parallel_ops_tb_top
    import fmp_pkg::*;
;
    logic core_clk, rst_n, instr_valid, mem_we, flag_clr, instr_ready, reject;
    logic [31:0] instr, mem_wdata, rd_data, mem_rdata, w;
    logic [7:0] mem_addr;
    logic [2:0] rd_sel;
    logic [6:0] status, m_st; // design and model status
    logic [31:0] m_rf [8]; // model registers
    int bad_count, cmp_count, stall_n;
    fmp_link_if link ();
    fmp_cpu_end fmp_cpu_end_i (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .LINK(link.host),
        .INSTR_VALID_I(instr_valid), .INSTR_I(instr), .MEM_WE_I(mem_we),
        .MEM_ADDR_I(mem_addr), .MEM_WDATA_I(mem_wdata), .INSTR_READY_O(instr_ready),
        .REJECT_O(reject), .MEM_RDATA_O(mem_rdata));
    fmp_fpu_end fmp_fpu_end_i (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .LINK(link.dev),
        .RD_SEL_I(rd_sel), .FLAG_CLR_I(flag_clr), .RD_DATA_O(rd_data), .STATUS_O(status));
    fmp_link_checker fmp_link_checker_i (.CORE_CLK_I(core_clk), .RST_N_I(rst_n),
        .issue_valid(link.issue_valid), .issue_word(link.issue_word),
        .load_word(link.load_word), .store_valid(link.store_valid),
        .store_addr(link.store_addr), .store_word(link.store_word));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_stat();
        cmp_count++;
        if (status !== m_st) begin
            bad_count++;
            $display("wrong value at %0t: status %b expected %b", $time, status, m_st);
        end
    endtask
    // encoders, written from the field layout, not the shared decode
    function automatic logic [31:0] pw(input logic [11:0] op, input logic [2:0] f, e, d, a,
        input logic [7:0] m);
        return {op, f, e, d, a, m};
    endfunction
    function automatic logic [31:0] sw(input logic [2:0] a, b, c, d, e, f);
        return {OPC_MPY_SUB, f, e, d, c, b, a};
    endfunction
    // model: move flags follow the loaded word
    task automatic m_load(input logic [2:0] r, input logic [31:0] d);
        m_rf[r] = d;
        m_st[ST_NEG] = d[31] && d[30:23] != 8'h00;
        m_st[ST_ZERO] = d[30:23] == 8'h00;
        m_st[ST_INT_NEG] = d[31];
        m_st[ST_INT_ZERO] = d == 32'h0;
    endtask
    // model: arithmetic result; latched flags only ever set
    task automatic m_arith(input logic [2:0] r, input logic [31:0] v, input logic u, o);
        m_rf[r] = v;
        m_st[ST_LAT_UNF] = m_st[ST_LAT_UNF] | u;
        m_st[ST_LAT_OVF] = m_st[ST_LAT_OVF] | o;
    endtask
    // present a word and hold it until ready; leaves valid up for back-to-back use
    task automatic issue(input logic [31:0] wd);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= wd;
        #1;
        stall_n = 0;
        while (instr_ready !== 1'b1) begin
            if (stall_n == 8) begin
                bad_count++;
                report_and_stop();
            end
            @(posedge core_clk);
            #1;
            stall_n++;
        end
    endtask
    task automatic idle();
        @(posedge core_clk);
        instr_valid <= 1'b0;
    endtask
    task automatic run(input logic [31:0] wd);
        issue(wd);
        idle();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wmem(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        mem_we <= 1'b1;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge core_clk);
        mem_we <= 1'b0;
    endtask
    // read back a register (m low) or memory word (m high); one cycle late
    task automatic look(input logic m, input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        if (m) begin
            mem_addr <= a;
        end else begin
            rd_sel <= a[2:0];
        end
        @(posedge core_clk);
        #1;
        chk_word(m ? mem_rdata : rd_data, exp);
    endtask
    // multiply paired with a load of word v into r
    task automatic pl(input logic [2:0] f, e, d, r, input logic [31:0] v, pv, input logic u, o);
        wmem({5'h0, r}, v);
        m_arith(d, pv, u, o);
        m_load(r, v);
        run(pw(OPC_MPY_LOAD, f, e, d, r, {5'h0, r}));
        chk_stat();
        look(1'b0, {5'h0, r}, v);
        look(1'b0, {5'h0, d}, pv);
    endtask
    // plain load; the paired multiply squares r6 (0 or 2.0) into r7
    task automatic ld(input logic [2:0] r, input logic [31:0] v);
        pl(3'h6, 3'h6, 3'h7, r, v, (m_rf[6] == 32'h40000000) ? 32'h40800000 : 32'h0, 0, 0);
    endtask
    task automatic sb(input logic [2:0] a, b, c, d, e, f, input logic [31:0] pv, dv,
        input logic u, o);
        m_arith(a, pv, u, o);
        m_arith(d, dv, u, o);
        run(sw(a, b, c, d, e, f));
        chk_stat();
        look(1'b0, {5'h0, a}, pv);
        look(1'b0, {5'h0, d}, dv);
    endtask
    task automatic fclear();
        @(posedge core_clk);
        flag_clr <= 1'b1;
        @(posedge core_clk);
        flag_clr <= 1'b0;
        m_st[1:0] = 2'h0;
    endtask
    // conflicting destinations: dropped, nothing changes
    task automatic rej(input logic [31:0] wd, input logic [2:0] r);
        issue(wd);
        idle();
        #1;
        chk_word({31'h0, reject}, 32'h1);
        repeat (4) @(posedge core_clk);
        chk_stat();
        look(1'b0, {5'h0, r}, m_rf[r]);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst_n, instr_valid, mem_we, flag_clr, instr, mem_wdata, mem_addr, rd_sel} = '0;
        bad_count = 0;
        cmp_count = 0;
        m_st = STAT_RST;
        foreach (m_rf[i]) m_rf[i] = 32'h0;
        void'($urandom(40));
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk_stat();
        ld(3'h6, 32'h40000000);
        // random loads, some with a zero exponent, one all zero
        for (int i = 0; i < 10; i++) begin
            w = $urandom;
            if (i % 3 == 0) w[30:23] = 8'h00;
            if (i == 1) w = 32'h0;
            ld(3'($urandom % 6), w);
        end
        ld(3'h0, 32'h7f000000);
        ld(3'h1, 32'h00800000);
        ld(3'h2, 32'h40400000);
        // product lands one slot later than the move
        wmem(8'h04, 32'h3f800000);
        @(posedge core_clk);
        rd_sel <= 3'h5;
        w = m_rf[5];
        m_arith(3'h5, 32'h40c00000, 0, 0);
        m_load(3'h4, 32'h3f800000);
        issue(pw(OPC_MPY_LOAD, 3'h2, 3'h6, 3'h5, 3'h4, 8'h04));
        idle();
        repeat (2) @(posedge core_clk);
        #1;
        chk_word(rd_data, w);
        @(posedge core_clk);
        #1;
        chk_word(rd_data, 32'h40c00000);
        look(1'b0, 8'h04, 32'h3f800000);
        // store r0 while r3 = r2 * r6
        m_arith(3'h3, 32'h40c00000, 0, 0);
        run(pw(OPC_MPY_STORE, 3'h2, 3'h6, 3'h3, 3'h0, 8'h80));
        chk_stat();
        look(1'b1, 8'h80, 32'h7f000000);
        look(1'b0, 8'h03, 32'h40c00000);
        // overflow, then underflow with overflow kept
        pl(3'h0, 3'h0, 3'h5, 3'h4, 32'hbf800000, 32'h7f800000, 0, 1);
        pl(3'h1, 3'h1, 3'h5, 3'h4, 32'h3f800000, 32'h0, 1, 0);
        fclear();
        sb(3'h5, 3'h6, 3'h2, 3'h4, 3'h2, 3'h6, 32'h40c00000, 32'h3f800000, 0, 0);
        sb(3'h5, 3'h0, 3'h0, 3'h4, 3'h6, 3'h6, 32'h7f800000, 32'h0, 0, 1);
        fclear();
        ld(3'h3, 32'hff000000);
        sb(3'h5, 3'h6, 3'h6, 3'h4, 3'h0, 3'h3, 32'h40800000, 32'h7f800000, 0, 1);
        fclear();
        ld(3'h3, 32'h00800001);
        sb(3'h5, 3'h6, 3'h6, 3'h4, 3'h3, 3'h1, 32'h40800000, 32'h0, 1, 0);
        rej(pw(OPC_MPY_LOAD, 3'h6, 3'h6, 3'h3, 3'h3, 8'h00), 3'h3);
        rej(sw(3'h4, 3'h6, 3'h6, 3'h4, 3'h6, 3'h6), 3'h4);
        // back to back: slot reader of r3 waits one cycle, store follows at once
        wmem(8'h01, 32'h41200000);
        m_arith(3'h3, 32'h40800000, 0, 0);
        m_arith(3'h4, 32'h0, 0, 0);
        m_arith(3'h5, 32'h41800000, 0, 0);
        m_load(3'h1, 32'h41200000);
        m_arith(3'h7, 32'h40800000, 0, 0);
        issue(sw(3'h3, 3'h6, 3'h6, 3'h4, 3'h6, 3'h6));
        issue(pw(OPC_MPY_LOAD, 3'h3, 3'h3, 3'h5, 3'h1, 8'h01));
        chk_word(32'(stall_n), 32'h1);
        issue(pw(OPC_MPY_STORE, 3'h6, 3'h6, 3'h7, 3'h2, 8'h81));
        chk_word(32'(stall_n), 32'h0);
        idle();
        repeat (4) @(posedge core_clk);
        chk_stat();
        look(1'b0, 8'h05, 32'h41800000);
        look(1'b0, 8'h01, 32'h41200000);
        look(1'b0, 8'h07, 32'h40800000);
        look(1'b1, 8'h81, m_rf[2]);
        report_and_stop();
    end
endmodule
